// >>> nfc_timebase.sv
// frequency counter with gate time-base for the field meter
`timescale 1ns/10ps
module nfc_timebase
	import nfc_pkg::*;
#(
	parameter int STAGES = 8,
	parameter int PROTON_TICKS = GATE_PROTON_TICKS,
	parameter int DEUT_TICKS = GATE_DEUT_TICKS,
	parameter int FREQ_TICKS = GATE_FREQ_TICKS
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// oscillator pin, asynchronous
	input wire logic osc_in,
	// selections
	input wire logic probe_deut,
	input wire logic disp_freq,
	input wire logic [$clog2(STAGES+1)-1:0] range_sel,
	// trims in clk cycles
	input wire logic [TRIM_W-1:0] trim_proton,
	input wire logic [TRIM_W-1:0] trim_deut,
	input wire logic [TRIM_W-1:0] trim_freq,
	// results
	output logic gate_out,
	output logic xfer_stb,
	output logic cnt_clr,
	output logic disp_is_freq,
	output logic [4*DIGITS-1:0] disp_bcd
);
	if (PROTON_TICKS < 2 || DEUT_TICKS < 2 || FREQ_TICKS < 2)
	begin : g_short
		$error("nfc_timebase: gate too short");
	end
	if (PROTON_TICKS >= 2**TICK_W || DEUT_TICKS >= 2**TICK_W ||
		FREQ_TICKS >= 2**TICK_W)
	begin : g_long
		$error("nfc_timebase: gate too long for counter");
	end

	// increment of one bcd digit with carry
	function automatic logic [4:0] bcd_inc(input logic [3:0] d);
		if (d == DEC_MAX)
			return {1'b1, DEC_ZERO};
		return {1'b0, d + 4'h1};
	endfunction

	// two flops before any logic sees the pin
	logic osc_s1_reg, osc_s2_reg, osc_d_reg;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
			osc_d_reg <= 1'b0;
		end
		else
		begin
			osc_s1_reg <= osc_in;
			osc_s2_reg <= osc_s1_reg;
			osc_d_reg <= osc_s2_reg;
		end
	end
	// limitation: oscillator must stay below a quarter of clk
	logic osc_en;
	assign osc_en = osc_s2_reg & ~osc_d_reg;

	logic tap_en;
	nfc_div_chain #(.STAGES(STAGES)) nfc_div_chain_i
	(
		.clk(clk),
		.rst_n(rst_n),
		.osc_en(osc_en),
		.range_sel(range_sel),
		.tap_en(tap_en)
	);

	// reference tick divider: 100 kHz enable
	logic [$clog2(REF_DIV)-1:0] ref_cnt_reg;
	logic ref_tick;
	assign ref_tick = (ref_cnt_reg == '0);
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ref_cnt_reg <= '0;
		else if (ref_tick)
			ref_cnt_reg <= ($clog2(REF_DIV))'(REF_DIV - 1);
		else
			ref_cnt_reg <= ref_cnt_reg - 1'b1;
	end

	nfc_state_t state_reg;
	nfc_mode_t mode_reg;
	logic [TICK_W-1:0] tick_reg;
	logic [TRIM_W-1:0] trim_reg;
	logic [1:0] pre_reg;
	logic [4*DIGITS-1:0] cnt_reg;

	// no start while the last result is moved or cleared: a count
	// landing in the clear cycle would be lost
	logic gate_start;
	assign gate_start = (state_reg == NFC_ST_IDLE) && ref_tick &&
		!xfer_stb && !cnt_clr;

	// mode is frozen for the whole gate
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mode_reg <= NFC_MODE_FREQ;
		else if (state_reg == NFC_ST_IDLE && !gate_start)
		begin
			if (disp_freq)
				mode_reg <= NFC_MODE_FREQ;
			else if (probe_deut)
				mode_reg <= NFC_MODE_DEUT;
			else
				mode_reg <= NFC_MODE_PROTON;
		end
	end

	// gate sequencer
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= NFC_ST_IDLE;
			tick_reg <= '0;
			trim_reg <= '0;
		end
		else
		begin
			case (state_reg)
				NFC_ST_IDLE:
					// gate starts on a reference edge for a clean count
					if (gate_start)
					begin
						state_reg <= NFC_ST_GATE;
						case (mode_reg)
							NFC_MODE_PROTON:
								tick_reg <= TICK_W'(PROTON_TICKS - 1);
							NFC_MODE_DEUT:
								tick_reg <= TICK_W'(DEUT_TICKS - 1);
							default:
								tick_reg <= TICK_W'(FREQ_TICKS - 1);
						endcase
						case (mode_reg)
							NFC_MODE_PROTON:
								trim_reg <= trim_proton;
							NFC_MODE_DEUT:
								trim_reg <= trim_deut;
							default:
								trim_reg <= trim_freq;
						endcase
					end
				NFC_ST_GATE:
					if (ref_tick)
					begin
						if (tick_reg == '0)
							state_reg <= NFC_ST_TRIM;
						else
							tick_reg <= tick_reg - 1'b1;
					end
				NFC_ST_TRIM:
					if (trim_reg == '0)
						state_reg <= NFC_ST_XFER;
					else
						trim_reg <= trim_reg - 1'b1;
				NFC_ST_XFER:
					state_reg <= NFC_ST_IDLE;
				default:
					state_reg <= NFC_ST_IDLE;
			endcase
		end
	end

	logic gate_open;
	assign gate_open = (state_reg == NFC_ST_GATE) ||
		(state_reg == NFC_ST_TRIM);

	// prescaler and decade chain
	logic pre_wrap;
	assign pre_wrap = (pre_reg == 2'(PRESCALE_PROTON - 1));
	logic count_en;
	always_comb
	begin
		if (mode_reg == NFC_MODE_PROTON)
			count_en = gate_open & tap_en & pre_wrap;
		else
			count_en = gate_open & tap_en;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || state_reg == NFC_ST_IDLE)
			pre_reg <= '0;
		else if (gate_open && tap_en)
			pre_reg <= pre_reg + 2'h1;
	end

	always_ff @(posedge clk)
	begin
		logic c;
		logic [4:0] r;
		c = count_en;
		r = '0;
		if (!rst_n || cnt_clr)
			cnt_reg <= '0;
		else
			for (int i = 0; i < DIGITS; i++)
				if (c)
				begin
					r = bcd_inc(cnt_reg[4*i +: 4]);
					cnt_reg[4*i +: 4] <= r[3:0];
					c = r[4];
				end
	end

	// outputs, all registered
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			gate_out <= 1'b0;
			xfer_stb <= 1'b0;
			cnt_clr <= 1'b1;
			disp_bcd <= '0;
			disp_is_freq <= 1'b1;
		end
		else
		begin
			gate_out <= gate_open;
			xfer_stb <= (state_reg == NFC_ST_XFER);
			// clear follows transfer, before the next gate opens
			cnt_clr <= xfer_stb;
			if (state_reg == NFC_ST_XFER)
			begin
				disp_bcd <= cnt_reg;
				disp_is_freq <= (mode_reg == NFC_MODE_FREQ);
			end
		end
	end
endmodule

// >>> nfc_pkg.sv
// package of constants for the field meter frequency counter time-base
package nfc_pkg;
	// reference clock and system clock
	localparam int CLK_HZ = 20000000;
	localparam int REF_HZ = 100000;
	localparam int REF_DIV = CLK_HZ / REF_HZ;
	// gate lengths in nanoseconds, as printed
	localparam longint GATE_PROTON_NS = 64'd939494640;
	localparam longint GATE_DEUT_NS = 64'd1530059900;
	localparam longint GATE_FREQ_NS = 64'd1000000000;
	localparam longint REF_PERIOD_NS = 64'd10000;
	// whole reference periods, rounded down; trim covers the rest
	localparam int GATE_PROTON_TICKS = int'(GATE_PROTON_NS / REF_PERIOD_NS);
	localparam int GATE_DEUT_TICKS = int'(GATE_DEUT_NS / REF_PERIOD_NS);
	localparam int GATE_FREQ_TICKS = int'(GATE_FREQ_NS / REF_PERIOD_NS);
	// trim range of about 80 ppm of a one-second gate, twice TRIM_PPM, in clk cycles
	localparam int TRIM_PPM = 40;
	localparam int TRIM_MAX_CYC = CLK_HZ / 1000000 * TRIM_PPM * 2;
	localparam int TRIM_W = $clog2(TRIM_MAX_CYC + 1);
	localparam int TICK_W = 18;
	localparam int DIGITS = 9;
	localparam int PRESCALE_PROTON = 4;
	// decade maximum
	localparam logic [3:0] DEC_MAX = 4'h9;
	localparam logic [3:0] DEC_ZERO = 4'h0;
	// mode selection codes
	typedef enum logic [1:0]
	{
		NFC_MODE_PROTON = 2'h0,
		NFC_MODE_DEUT = 2'h1,
		NFC_MODE_FREQ = 2'h2
	} nfc_mode_t;
	typedef enum logic [3:0]
	{
		NFC_ST_IDLE = 4'h1,
		NFC_ST_GATE = 4'h2,
		NFC_ST_TRIM = 4'h4,
		NFC_ST_XFER = 4'h8
	} nfc_state_t;
endpackage

// >>> nfc_div_chain.sv
// divide-by-two range chain with tap selection
`timescale 1ns/10ps
module nfc_div_chain
	import nfc_pkg::*;
#(
	parameter int STAGES = 8
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// synchronised oscillator edge enable
	input wire logic osc_en,
	// range select and tap output
	input wire logic [$clog2(STAGES+1)-1:0] range_sel,
	output logic tap_en
);
	// refused at elaboration, the tap select cannot address more
	if (STAGES < 1 || STAGES > 30)
	begin : g_bad_stages
		$error("nfc_div_chain: STAGES out of range");
	end

	logic [STAGES-1:0] div_reg;
	logic [STAGES:0] carry;

	// ripple enables model each stage as a toggle flip-flop
	always_comb
	begin
		carry[0] = osc_en;
		for (int i = 0; i < STAGES; i++)
			carry[i+1] = carry[i] & div_reg[i];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			div_reg <= '0;
		else
			div_reg <= div_reg ^ carry[STAGES-1:0];
	end

	// one pulse per period of the selected tap
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			tap_en <= 1'b0;
		else if (range_sel > STAGES[$clog2(STAGES+1)-1:0])
			tap_en <= 1'b0;
		else
			tap_en <= carry[range_sel];
	end
endmodule

// >>> nfc_osc_model.sv
// oscillator model driving the counter pin
`timescale 1ns/10ps
module nfc_osc_model
(
	// oscillator pin
	output logic osc
);
	// free running, never stops between gates
	initial
	begin
		osc = 1'b0;
		forever #200 osc = ~osc;
	end
endmodule

// >>> nfc_timebase_checker.sv
// port assertions for the counter time-base
`timescale 1ns/10ps
module nfc_timebase_checker
	import nfc_pkg::*;
#(
	parameter int PROTON_TICKS = GATE_PROTON_TICKS,
	parameter int DEUT_TICKS = GATE_DEUT_TICKS,
	parameter int FREQ_TICKS = GATE_FREQ_TICKS
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// results
	input wire logic gate_out,
	input wire logic xfer_stb,
	input wire logic cnt_clr,
	input wire logic [4*DIGITS-1:0] disp_bcd
);
	int glen;
	// shortest and longest countdown over the three modes
	localparam int MIN_T = PROTON_TICKS < DEUT_TICKS ?
		(PROTON_TICKS < FREQ_TICKS ? PROTON_TICKS : FREQ_TICKS) :
		(DEUT_TICKS < FREQ_TICKS ? DEUT_TICKS : FREQ_TICKS);
	localparam int MAX_T = PROTON_TICKS > DEUT_TICKS ?
		(PROTON_TICKS > FREQ_TICKS ? PROTON_TICKS : FREQ_TICKS) :
		(DEUT_TICKS > FREQ_TICKS ? DEUT_TICKS : FREQ_TICKS);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// open gate length, catches a gate shorter or longer than any mode with any trim allows
	always_ff @(posedge clk)
		glen <= gate_out ? glen + 1 : 0;
	property p_clr; xfer_stb |=> cnt_clr && !xfer_stb; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_why; $rose(cnt_clr) |-> $past(xfer_stb); endproperty
	a_why: assert property (p_why) else $error("stray clear");
	property p_one; cnt_clr && $past(xfer_stb) |=> !cnt_clr; endproperty
	a_one: assert property (p_one) else $error("long clear");
	property p_hold; !xfer_stb |-> $stable(disp_bcd); endproperty
	a_hold: assert property (p_hold) else $error("display moved");
	property p_end; $fell(gate_out) |-> xfer_stb; endproperty
	a_end: assert property (p_end) else $error("no strobe");
	property p_in; gate_out |-> !xfer_stb && !cnt_clr; endproperty
	a_in: assert property (p_in) else $error("strobe in gate");
	property p_next; $fell(cnt_clr) |-> ##[1:202] $rose(gate_out); endproperty
	a_next: assert property (p_next) else $error("no gate");
	property p_len; $fell(gate_out) |-> glen >= REF_DIV * MIN_T + 1
		&& glen <= REF_DIV * MAX_T + TRIM_MAX_CYC + 1; endproperty
	a_len: assert property (p_len) else $error("bad length");
endmodule

// >>> tb_nfc_timebase.sv
// bench for the counter time-base
`timescale 1ns/10ps
module tb_nfc_timebase;
	logic clk, rst_n, osc_in, probe_deut, disp_freq;
	logic gate_out, xfer_stb, cnt_clr, disp_is_freq;
	logic [3:0] range_sel;
	logic [35:0] disp_bcd;
	logic [10:0] trim_p, trim_d, trim_f;
	int bad_count = 0, n_checks = 0, edges = 0;
	nfc_osc_model nfc_osc_model_i (.osc(osc_in));
	nfc_timebase #(.PROTON_TICKS(3), .DEUT_TICKS(4), .FREQ_TICKS(5))
		nfc_timebase_i (.clk(clk), .rst_n(rst_n), .osc_in(osc_in),
		.probe_deut(probe_deut), .disp_freq(disp_freq),
		.range_sel(range_sel), .trim_proton(trim_p),
		.trim_deut(trim_d), .trim_freq(trim_f), .gate_out(gate_out),
		.xfer_stb(xfer_stb), .cnt_clr(cnt_clr),
		.disp_is_freq(disp_is_freq), .disp_bcd(disp_bcd));
	always @(posedge osc_in)
		edges += gate_out;
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d bad %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, lo, hi);
		n_checks++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			bad_count++;
			$display("BAD %0t %h %h %h", $time, got, lo, hi);
		end
	endtask
	function automatic logic [35:0] dec(input logic [35:0] b);
		dec = '0;
		for (int i = 8; i >= 0; i--)
			dec = dec * 10 + b[4*i +: 4];
	endfunction
	// every wait is counted, so a stuck gate ends the run
	task automatic step(inout int n);
		@(posedge clk);
		#5;
		n++;
		if (n > 5000)
		begin
			bad_count++;
			print_verdict();
		end
	endtask
	// one gate passes to latch the mode, the next is measured
	task automatic gate(input logic f, d, flip, input int r, len, div);
		int n = 0;
		int g = 0;
		step(n);
		disp_freq = f;
		probe_deut = d;
		range_sel = 4'(r);
		while (gate_out !== 1'b1)
			step(n);
		while (gate_out === 1'b1)
			step(n);
		edges = 0;
		while (gate_out !== 1'b1)
			step(n);
		while (gate_out === 1'b1)
		begin
			step(n);
			g++;
			if (flip && g == 50)
				disp_freq = ~f;
		end
		chk(36'(g), 36'(len - 2), 36'(len + 2));
		while (xfer_stb !== 1'b1)
			step(n);
		g = (edges >> r) / div;
		chk(dec(disp_bcd), 36'(g - 1), 36'(g + 1));
		chk(36'(disp_is_freq), 36'(f), 36'(f));
		step(n);
		chk(36'(cnt_clr), 36'h1, 36'h1);
	endtask
	task automatic t_freq();
		gate(1'b1, 1'b0, 1'b0, 0, 1031, 1);
		$display("freq gate done");
	endtask
	task automatic t_proton();
		gate(1'b0, 1'b0, 1'b1, 0, 611, 4);
		$display("proton gate done");
	endtask
	task automatic t_deut();
		gate(1'b0, 1'b1, 1'b0, 1, 821, 1);
		$display("deuteron gate done");
	endtask
	task automatic t_trim();
		trim_f = 11'h000;
		gate(1'b1, 1'b0, 1'b0, 0, 1001, 1);
		$display("trim change gate done");
	endtask
	initial
	begin
		rst_n = 1'b0;
		disp_freq = 1'b1;
		probe_deut = 1'b0;
		range_sel = 4'h0;
		trim_p = 11'h00a;
		trim_d = 11'h014;
		trim_f = 11'h01e;
		repeat (4) @(posedge clk);
		#5;
		chk(36'(cnt_clr), 36'h1, 36'h1);
		rst_n = 1'b1;
		t_freq();
		t_proton();
		t_deut();
		t_trim();
		print_verdict();
	end
endmodule
bind nfc_timebase nfc_timebase_checker #(.PROTON_TICKS(PROTON_TICKS),
	.DEUT_TICKS(DEUT_TICKS), .FREQ_TICKS(FREQ_TICKS))
	nfc_timebase_checker_i (.clk(clk),
	.rst_n(rst_n), .gate_out(gate_out), .xfer_stb(xfer_stb),
	.cnt_clr(cnt_clr), .disp_bcd(disp_bcd));
